/* File: clksw_cfg.svh */
// Purpose: offsets, field positions, keys and counts of the clock switch
// Assumes: 32-bit APB, one register per aligned word
// Notes:   definitions only
`ifndef CLKSW_CFG_SVH
`define CLKSW_CFG_SVH

`define OSC_CONTROL_OFFSET   12'h000
`define RC_TUNE_OFFSET       12'h004
`define CFG_STATUS_OFFSET    12'h008

`define CUR_OSC_LSB          12
`define NEXT_OSC_LSB         8
`define PLL_LOCK_BIT         5
`define CLOCK_FAIL_BIT       3
`define KEEP_ON_BIT          1
`define SWITCH_REQ_BIT       0
`define RC_TUNE_WIDTH        6

`define HIGH_KEY_FIRST       8'h78
`define HIGH_KEY_SECOND      8'h9A
`define LOW_KEY_FIRST        8'h46
`define LOW_KEY_SECOND       8'h57

`define SETTLE_NEW_CYCLES    4'hA
`define CFG_SWITCH_RESET     2'h3
`define CFG_INITIAL_RESET    3'h0
`define RC_TUNE_RESET        6'h00

`endif

/* File: clksw_pkg.sv */
// Purpose: types shared by the clock switch controller
// Assumes: nothing
// Notes:   oscillator codes follow the selection field encoding
package clksw_pkg;

    typedef enum logic [2:0] {
        OSC_FAST_RC       = 3'h0,
        OSC_FAST_RC_PLL   = 3'h1,
        OSC_PRIMARY       = 3'h2,
        OSC_PRIMARY_PLL   = 3'h3,
        OSC_SECONDARY     = 3'h4,
        OSC_LOW_POWER_RC  = 3'h5,
        OSC_RESERVED      = 3'h6,
        OSC_FAST_RC_DIV   = 3'h7
    } osc_code_type;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_CHECK  = 6'h02,
        ST_START  = 6'h04,
        ST_LOCK   = 6'h08,
        ST_SETTLE = 6'h10,
        ST_SWAP   = 6'h20
    } switch_state_type;

endpackage : clksw_pkg

/* File: clock_switch_controller.sv */
// Purpose: run-time system clock switch with byte-wise unlock and handshake
// Assumes: oscillator status inputs synchronous to pclk
// Notes:   new_clk_tick pulses once per cycle of the incoming clock
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "clksw_cfg.svh"

// Functional notes
// - switching and monitor only when config bit zero
// - disabled: next ignored, current shows initial config
// - disabled: switch request ignored, reads zero
// - high byte keys 78h 9Ah, then selection
// - low byte keys 46h 57h, then request
// - equal current and next: clear request, abort
// - valid switch clears lock and fail flags
// - start new oscillator, crystal waits start-up timer
// - PLL source waits for PLL lock
// - count 10 new clock cycles, then switch
// - success clears request, copies next to current
// - old source off, except kept low-power or secondary
// - CPU never stalled during switching
// - six-bit tuning field, centre at zero
// - any of four sources selectable anytime
// - config 1x off, 01 switch only, 00 both
module clock_switch_controller
    import clksw_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic [1:0]  clock_switch_cfg,
    input  wire logic [2:0]  initial_osc_cfg,
    input  wire logic        watchdog_enable,
    input  wire logic        primary_ost_done,
    input  wire logic        pll_lock,
    input  wire logic        new_clk_tick,
    input  wire logic        clock_fail_event,
    output var  logic [2:0]  sys_clk_select,
    output var  logic [3:0]  osc_enable,
    output var  logic        pll_enable,
    output var  logic [5:0]  rc_tune_value,
    output var  logic        switch_busy
);
    import clksw_pkg::*;

    // one-hot oscillator source: 0 primary, 1 secondary, 2 fast rc, 3 low_power_rc_osc
    function automatic logic [3:0] source_of(input logic [2:0] code);
        logic [3:0] src;
        src = 4'h4;
        if (code == OSC_PRIMARY || code == OSC_PRIMARY_PLL)
            src = 4'h1;
        else if (code == OSC_SECONDARY)
            src = 4'h2;
        else if (code == OSC_LOW_POWER_RC)
            src = 4'h8;
        return src;
    endfunction : source_of

    function automatic logic uses_pll(input logic [2:0] code);
        return (code == OSC_FAST_RC_PLL) || (code == OSC_PRIMARY_PLL);
    endfunction : uses_pll

    switch_state_type state;
    switch_state_type next_state;

    logic [1:0]  cfg_switch;
    logic [2:0]  cfg_initial;
    logic        cfg_taken;
    logic [2:0]  current_osc_status;
    logic [2:0]  next_osc_select;
    logic [2:0]  target_osc;
    logic        switch_request;
    logic        pll_locked;
    logic        clock_fail_flag;
    logic        secondary_osc_keep_on;
    logic [3:0]  settle_count;
    logic [1:0]  unlock_stage [2];
    logic [1:0]  next_unlock_stage [2];
    logic [1:0]  unlock_grant;

    wire logic       switch_enabled  = ~cfg_switch[1];
    wire logic       monitor_enabled = (cfg_switch == 2'h0);
    wire logic       setup_phase     = psel & ~penable;
    wire logic       wr_en           = psel & penable & pwrite;
    wire logic       hit_osc  = (paddr == `OSC_CONTROL_OFFSET);
    wire logic       hit_tune = (paddr == `RC_TUNE_OFFSET);
    wire logic       hit_cfg  = (paddr == `CFG_STATUS_OFFSET);
    wire logic       hit_any  = hit_osc | hit_tune | hit_cfg;
    wire logic [7:0] key_first  [2] = '{`LOW_KEY_FIRST, `HIGH_KEY_FIRST};
    wire logic [7:0] key_second [2] = '{`LOW_KEY_SECOND, `HIGH_KEY_SECOND};
    wire logic       new_src_ready = (source_of(target_osc) == 4'h1) ?
                                     primary_ost_done : 1'b1;
    wire logic       settle_done   = new_clk_tick &&
                         (settle_count == `SETTLE_NEW_CYCLES - 4'h1);
    wire logic       start_switch  = (state == ST_CHECK) &&
                                     (target_osc != current_osc_status);
    wire logic       abort_switch  = (state == ST_CHECK) &&
                                     (target_osc == current_osc_status);
    wire logic       finish_switch = (state == ST_SWAP);
    wire logic       hi_grant_wr   = unlock_grant[1];
    wire logic       lo_grant_wr   = unlock_grant[0];
    wire logic       req_write     = lo_grant_wr &&
                         pwdata[`SWITCH_REQ_BIT] && switch_enabled;
    wire logic       busy_now      = (state != ST_IDLE);
    wire logic [3:0] keep_sources  =
        {watchdog_enable | monitor_enabled, 2'h0, 1'b0} |
        {2'h0, secondary_osc_keep_on, 1'b0};
    wire logic [3:0] next_osc_enable = source_of(current_osc_status) |
        (busy_now ? source_of(target_osc) : 4'h0) | keep_sources;
    wire logic       next_pll_enable = uses_pll(current_osc_status) |
        (busy_now & uses_pll(target_osc));
    wire logic [31:0] osc_word = {17'h0000,
        current_osc_status, 1'b0, next_osc_select, 2'h0,
        pll_locked, 1'b0, clock_fail_flag, 1'b0,
        secondary_osc_keep_on, switch_request & switch_enabled};
    wire logic [31:0] next_prdata =
        hit_osc  ? osc_word :
        hit_tune ? {26'h0000000, rc_tune_value} :
        hit_cfg  ? {26'h0000000, switch_busy, cfg_initial,
                    cfg_switch} : 32'h00000000;

    // the two low byte lanes of the control word each have their own unlock tracker
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_unlock
            wire logic       lane_write = wr_en && hit_osc &&
                                          (pstrb == (4'h1 << g));
            wire logic [7:0] lane_val   = pwdata[8*g +: 8];
            assign unlock_grant[g] = lane_write &&
                                     (unlock_stage[g] == 2'h2);
            always_comb
            begin
                next_unlock_stage[g] = unlock_stage[g];
                if (wr_en)
                begin
                    if (lane_write && unlock_stage[g] == 2'h0 &&
                        lane_val == key_first[g])
                        next_unlock_stage[g] = 2'h1;
                    else if (lane_write && unlock_stage[g] == 2'h1 &&
                             lane_val == key_second[g])
                        next_unlock_stage[g] = 2'h2;
                    else
                        next_unlock_stage[g] = 2'h0;
                end
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    unlock_stage[g] <= 2'h0;
                else
                    unlock_stage[g] <= next_unlock_stage[g];
            end
        end
    endgenerate

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
                if (switch_request && switch_enabled)
                    next_state = ST_CHECK;
            ST_CHECK:
                next_state = abort_switch ? ST_IDLE : ST_START;
            ST_START:
                if (new_src_ready)
                    next_state = uses_pll(target_osc) ? ST_LOCK
                                                      : ST_SETTLE;
            ST_LOCK:
                if (pll_lock)
                    next_state = ST_SETTLE;
            ST_SETTLE:
                if (settle_done)
                    next_state = ST_SWAP;
            ST_SWAP:
                next_state = ST_IDLE;
        endcase
    end

    // configuration fuses are captured once, the cycle after reset release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_taken   <= 1'b0;
            cfg_switch  <= `CFG_SWITCH_RESET;
            cfg_initial <= `CFG_INITIAL_RESET;
        end
        else if (!cfg_taken)
        begin
            cfg_taken   <= 1'b1;
            cfg_switch  <= clock_switch_cfg;
            cfg_initial <= initial_osc_cfg;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state        <= ST_IDLE;
            target_osc   <= `CFG_INITIAL_RESET;
            settle_count <= 4'h0;
        end
        else
        begin
            state <= next_state;
            if (state == ST_IDLE)
                target_osc <= next_osc_select;
            if (state != ST_SETTLE)
                settle_count <= 4'h0;
            else if (new_clk_tick)
                settle_count <= settle_count + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            current_osc_status <= `CFG_INITIAL_RESET;
        else if (!switch_enabled || !cfg_taken)
            current_osc_status <= cfg_taken ? cfg_initial
                                            : initial_osc_cfg;
        else if (finish_switch)
            current_osc_status <= target_osc;
    end

    // selection is accepted only right after the high byte unlock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            next_osc_select <= `CFG_INITIAL_RESET;
        else if (!cfg_taken)
            next_osc_select <= initial_osc_cfg;
        else if (hi_grant_wr)
            next_osc_select <= pwdata[`NEXT_OSC_LSB +: 3];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            switch_request <= 1'b0;
        else if (!switch_enabled)
            switch_request <= 1'b0;
        else if (abort_switch || finish_switch)
            switch_request <= 1'b0;
        else if (req_write)
            switch_request <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            secondary_osc_keep_on <= 1'b0;
        else if (lo_grant_wr)
            secondary_osc_keep_on <= pwdata[`KEEP_ON_BIT];
    end

    // hardware set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clock_fail_flag <= 1'b0;
        else if (clock_fail_event && monitor_enabled)
            clock_fail_flag <= 1'b1;
        else if (start_switch)
            clock_fail_flag <= 1'b0;
        else if (lo_grant_wr && !pwdata[`CLOCK_FAIL_BIT])
            clock_fail_flag <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pll_locked <= 1'b0;
        else if (start_switch)
            pll_locked <= 1'b0;
        else if (state == ST_LOCK)
            pll_locked <= pll_lock;
        else if (state == ST_IDLE)
            pll_locked <= pll_lock & uses_pll(current_osc_status);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rc_tune_value <= `RC_TUNE_RESET;
        else if (wr_en && hit_tune && pstrb[0])
            rc_tune_value <= pwdata[`RC_TUNE_WIDTH-1:0];
    end

    // bus never stretches, so code keeps running while switching
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready <= 1'b1;
            if (setup_phase)
            begin
                pslverr <= ~hit_any;
                prdata  <= pwrite ? 32'h00000000 : next_prdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_clk_select <= `CFG_INITIAL_RESET;
            osc_enable     <= 4'h0;
            pll_enable     <= 1'b0;
            switch_busy    <= 1'b0;
        end
        else
        begin
            sys_clk_select <= current_osc_status;
            osc_enable     <= next_osc_enable;
            pll_enable     <= next_pll_enable;
            switch_busy    <= busy_now;
        end
    end

endmodule : clock_switch_controller
`default_nettype wire

/* File: clock_switch_controller_assertions.sv */
// Purpose: port checks for the clock switch controller
// Assumes: config straps change only under reset
// Notes:   bound to every instance of the design top
`timescale 1ns/10ps
`default_nettype none
`include "clksw_cfg.svh"
module clock_switch_controller_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic [1:0]  clock_switch_cfg,
    input wire logic [2:0]  initial_osc_cfg,
    input wire logic        primary_ost_done,
    input wire logic        pll_lock,
    input wire logic        new_clk_tick,
    input wire logic [2:0]  sys_clk_select,
    input wire logic [5:0]  rc_tune_value,
    input wire logic        switch_busy
);
    wire        acc     = psel && penable;
    wire  [5:0] tune_wr = pwdata[5:0];
    logic       busy_q;
    logic [3:0] ticks;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            busy_q <= 1'h0;
        else
            busy_q <= switch_busy;
    // new clock ticks seen since the run began, saturating
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            ticks <= 4'h0;
        else if (!switch_busy && !busy_q)
            ticks <= 4'h0;
        else if (new_clk_tick && ticks != 4'hF)
            ticks <= ticks + 4'h1;

    property p_off_idle; clock_switch_cfg[1] |-> !switch_busy; endproperty
    a_off_idle: assert property (p_off_idle) else $error("busy while off");
    property p_off_sel; clock_switch_cfg[1] && $past(presetn, 2)
        |-> sys_clk_select == initial_osc_cfg; endproperty
    a_off_sel: assert property (p_off_sel) else $error("source moved");
    property p_off_req; clock_switch_cfg[1] && acc && !pwrite
        && paddr == `OSC_CONTROL_OFFSET |-> !prdata[0]; endproperty
    a_off_req: assert property (p_off_req) else $error("request seen");
    property p_no_stall; acc |-> pready; endproperty
    a_no_stall: assert property (p_no_stall) else $error("bus stalled");
    property p_settle; $past(presetn, 3) && $changed(sys_clk_select)
        |-> ticks >= 4'hA; endproperty
    a_settle: assert property (p_settle) else $error("settle short");
    property p_lock; $past(presetn, 2) && $changed(sys_clk_select)
        && sys_clk_select[0] && !sys_clk_select[2] |-> $past(pll_lock);
    endproperty
    a_lock: assert property (p_lock) else $error("no pll lock");
    property p_ost; $past(presetn, 3) && $changed(sys_clk_select)
        && sys_clk_select[2:1] == 2'h1 |-> $past(primary_ost_done);
    endproperty
    a_ost: assert property (p_ost) else $error("start-up skipped");
    property p_tune; acc && pwrite && pstrb[0] && paddr == `RC_TUNE_OFFSET
        |=> rc_tune_value == $past(tune_wr); endproperty
    a_tune: assert property (p_tune) else $error("tune not loaded");
endmodule : clock_switch_controller_assertions

bind clock_switch_controller clock_switch_controller_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .clock_switch_cfg(clock_switch_cfg),
    .initial_osc_cfg(initial_osc_cfg), .primary_ost_done(primary_ost_done),
    .pll_lock(pll_lock), .new_clk_tick(new_clk_tick),
    .sys_clk_select(sys_clk_select), .rc_tune_value(rc_tune_value),
    .switch_busy(switch_busy)
);
`default_nettype wire

/* File: tb.sv */
// Purpose: self-checking bench for the clock switch controller
// Assumes: APB answers whenever pready is high
// Notes:   the new clock ticks on every other pclk cycle
`timescale 1ns/10ps
`default_nettype none
`include "clksw_cfg.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
$display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
    import clksw_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, osc_enable;
    logic [1:0]  clock_switch_cfg;
    logic [2:0]  initial_osc_cfg, sys_clk_select;
    logic        watchdog_enable, primary_ost_done, pll_lock, new_clk_tick;
    logic        clock_fail_event, pll_enable, switch_busy, er, tick_en;
    logic [5:0]  rc_tune_value;
    logic [5:0]  tunes [3] = '{6'h1F, 6'h20, 6'h3F};
    int          failures, comparisons, cycles;

    clock_switch_controller u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_switch_cfg(clock_switch_cfg),
        .initial_osc_cfg(initial_osc_cfg), .watchdog_enable(watchdog_enable),
        .primary_ost_done(primary_ost_done), .pll_lock(pll_lock),
        .new_clk_tick(new_clk_tick), .clock_fail_event(clock_fail_event),
        .sys_clk_select(sys_clk_select), .osc_enable(osc_enable),
        .pll_enable(pll_enable), .rc_tune_value(rc_tune_value),
        .switch_busy(switch_busy)
    );

    always #5 pclk = ~pclk;
    always @(posedge pclk)
        new_clk_tick <= tick_en && !new_clk_tick;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        xfer(1'h1, a, d, s);
    endtask : wr

    task automatic rdr(input logic [11:0] a);
        xfer(1'h0, a, 32'h0, 4'hF);
    endtask : rdr

    task automatic switch_to(input logic [2:0] nx,
                             input logic [7:0] low);
        wr(`OSC_CONTROL_OFFSET, 32'h7800, 4'h2);
        wr(`OSC_CONTROL_OFFSET, 32'h9A00, 4'h2);
        wr(`OSC_CONTROL_OFFSET, {21'h0, nx, 8'h0}, 4'h2);
        wr(`OSC_CONTROL_OFFSET, 32'h46, 4'h1);
        wr(`OSC_CONTROL_OFFSET, 32'h57, 4'h1);
        wr(`OSC_CONTROL_OFFSET, {24'h0, low}, 4'h1);
    endtask : switch_to

    task automatic wait_sel(input logic [2:0] code);
        repeat (400)
            if (sys_clk_select !== code)
                @(posedge pclk);
        `CHK(sys_clk_select, code)
        rdr(`OSC_CONTROL_OFFSET);
        `CHK({rd[14:12], rd[0]}, {code, 1'h0})
    endtask : wait_sel

    task automatic do_reset(input logic [1:0] c, input logic [2:0] i);
        @(posedge pclk);
        presetn <= 1'h0;
        clock_switch_cfg <= c;
        initial_osc_cfg <= i;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
    endtask : do_reset

    task automatic pulse_fail();
        @(posedge pclk);
        clock_fail_event <= 1'h1;
        @(posedge pclk);
        clock_fail_event <= 1'h0;
        rdr(`OSC_CONTROL_OFFSET);
    endtask : pulse_fail

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, tick_en} = '0;
        {paddr, pwdata, pstrb, clock_switch_cfg, initial_osc_cfg} = '0;
        {primary_ost_done, pll_lock, new_clk_tick, clock_fail_event} = '0;
        watchdog_enable = 1'h1;
        do_reset(2'h2, OSC_PRIMARY);
        rdr(`OSC_CONTROL_OFFSET);
        `CHK(rd[14:12], 3'h2)
        rdr(`CFG_STATUS_OFFSET);
        `CHK(rd[5:0], 6'h0A)
        rdr(`RC_TUNE_OFFSET);
        `CHK(rd, 32'h0)
        switch_to(OSC_FAST_RC, 8'h01);
        rdr(`OSC_CONTROL_OFFSET);
        `CHK({rd[0], switch_busy, sys_clk_select}, 5'h02)
        foreach (tunes[k])
        begin
            wr(`RC_TUNE_OFFSET, {26'h0, tunes[k]}, 4'h1);
            rdr(`RC_TUNE_OFFSET);
            `CHK(rd, {26'h0, tunes[k]})
        end
        wr(`RC_TUNE_OFFSET, 32'h15, 4'hE);
        rdr(`RC_TUNE_OFFSET);
        `CHK(rd, 32'h3F)
        rdr(12'h00C);
        `CHK({er, rd}, 33'h100000000)
        do_reset(2'h1, OSC_FAST_RC);
        pulse_fail();
        `CHK(rd[3], 1'h0)
        do_reset(2'h0, OSC_FAST_RC);
        tick_en <= 1'h1;
        pulse_fail();
        `CHK(rd[3], 1'h1)
        switch_to(OSC_FAST_RC, 8'h09);
        // request clears two edges after the enabling write
        @(posedge pclk);
        rdr(`OSC_CONTROL_OFFSET);
        `CHK({rd[3], rd[0], sys_clk_select}, 5'h10)
        wr(`OSC_CONTROL_OFFSET, 32'h7800, 4'h2);
        wr(`RC_TUNE_OFFSET, 32'h0, 4'h1);
        wr(`OSC_CONTROL_OFFSET, 32'h9A00, 4'h2);
        wr(`OSC_CONTROL_OFFSET, 32'h0400, 4'h2);
        rdr(`OSC_CONTROL_OFFSET);
        `CHK(rd[10:8], 3'h0)
        switch_to(OSC_PRIMARY_PLL, 8'h09);
        repeat (30) @(posedge pclk);
        rdr(`OSC_CONTROL_OFFSET);
        `CHK({rd[3], rd[0], sys_clk_select}, 5'h08)
        primary_ost_done <= 1'h1;
        repeat (30) @(posedge pclk);
        `CHK(sys_clk_select, 3'h0)
        rdr(`OSC_CONTROL_OFFSET);
        `CHK({rd[5], rd[0]}, 2'h1)
        pll_lock <= 1'h1;
        wait_sel(OSC_PRIMARY_PLL);
        `CHK(rd[5], 1'h1)
        `CHK({osc_enable, pll_enable}, 5'h13)
        switch_to(OSC_SECONDARY, 8'h03);
        wait_sel(OSC_SECONDARY);
        `CHK({osc_enable, pll_enable}, 5'h14)
        switch_to(OSC_LOW_POWER_RC, 8'h03);
        wait_sel(OSC_LOW_POWER_RC);
        `CHK(osc_enable, 4'hA)
        switch_to(OSC_FAST_RC, 8'h01);
        wait_sel(OSC_FAST_RC);
        `CHK(osc_enable, 4'hC)
        wrap_up();
    end
endmodule : tb
`default_nettype wire
